// ===== logic/odt_pkg.sv
/*
 Shared constants and types for the opcode decode and timing block.
 Assumes a single 100 MHz clock and synchronous active-high reset.
*/
`default_nettype none
package odt_pkg;
   // -----------------------------------------------------------------
   // Timing counts
   // -----------------------------------------------------------------
   localparam logic [4:0] STACK_BASE_CYC   = 5'h05;
   localparam logic [4:0] STACK_BYTE_CYC   = 5'h01;
   localparam logic [4:0] LBR_NOT_CYC      = 5'h05;
   localparam logic [4:0] LBR_TAKEN_CYC    = 5'h06;
   localparam logic [4:0] PRODUCT_CYC      = 5'h0b;
   localparam logic [4:0] WAIT_MIN_CYC     = 5'h04;
   localparam logic [4:0] TRAP_CYC         = 5'h13;
   localparam logic [4:0] RET_SHORT_CYC    = 5'h06;
   localparam logic [4:0] RET_LONG_CYC     = 5'h0f;
   localparam logic [4:0] FAR_CALL_CYC     = 5'h09;
   localparam logic [4:0] DEC_FIX_CYC      = 5'h02;
   localparam logic [4:0] SHORT_BR_CYC     = 5'h03;
   localparam logic [4:0] RMW_EXT_CYC      = 5'h07;
   localparam logic [4:0] RMW_IDX_CYC      = 5'h06;
   localparam logic [4:0] RMW_DIR_CYC      = 5'h06;
   localparam logic [4:0] INH_CYC          = 5'h02;
   localparam logic [4:0] SWAP_CYC         = 5'h08;
   localparam logic [4:0] COPY_CYC         = 5'h06;
   localparam logic [4:0] ZS_EXT_CYC       = 5'h07;
   // -----------------------------------------------------------------
   // Opcodes and bus constants
   // -----------------------------------------------------------------
   localparam logic [7:0]  OP_PAGE2        = 8'h10;
   localparam logic [7:0]  OP_PAGE3        = 8'h11;
   localparam logic [7:0]  OP_EVENT_WAIT   = 8'h13;
   localparam logic [7:0]  OP_FAR_JUMP     = 8'h16;
   localparam logic [7:0]  OP_FAR_CALL     = 8'h17;
   localparam logic [7:0]  OP_DEC_FIX      = 8'h19;
   localparam logic [7:0]  OP_SWAP         = 8'h1e;
   localparam logic [7:0]  OP_COPY         = 8'h1f;
   localparam logic [7:0]  OP_JUMP_ALWAYS  = 8'h20;
   localparam logic [7:0]  OP_TRAP_RET     = 8'h3b;
   localparam logic [7:0]  OP_PRODUCT      = 8'h3d;
   localparam logic [7:0]  OP_SOFT_TRAP    = 8'h3f;
   localparam logic [7:0]  OP_ZS_EXT       = 8'h7f;
   localparam logic [15:0] DUMMY_ADDR      = 16'hffff;
   localparam logic [7:0]  ZERO_DATA       = 8'h00;
   localparam logic [3:0]  REGSEL_CC       = 4'ha;
   localparam int          RAM_DEPTH       = 256;

   typedef enum logic [3:0] {
      ODT_NONE  = 4'h0, ODT_RMW   = 4'h1, ODT_ZSTORE = 4'h2, ODT_BR_S  = 4'h3,
      ODT_BR_L  = 4'h4, ODT_CALL  = 4'h5, ODT_STACK  = 4'h6, ODT_TRAP  = 4'h7,
      ODT_RET   = 4'h8, ODT_PROD  = 4'h9, ODT_WAIT   = 4'ha, ODT_FIX   = 4'hb,
      ODT_XREG  = 4'hc, ODT_INH   = 4'hd, ODT_PREFIX = 4'he, ODT_ILL   = 4'hf
   } odt_op_e;

   typedef enum logic [2:0] {
      AM_INH = 3'h0, AM_DIR = 3'h1, AM_EXT = 3'h2, AM_IDX = 3'h3, AM_REL = 3'h4, AM_IMM = 3'h5
   } odt_mode_e;

   typedef struct packed {
      odt_op_e    op;
      odt_mode_e  mode;
      logic [1:0] bytes;
      logic [4:0] base_cyc;
      logic       flags_hit;
      logic       illegal;
   } odt_dec_s;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        rd;
      logic        wr;
   } odt_bus_s;
endpackage
`default_nettype wire

// ===== logic/odt_rom.sv
/*
 Registered-output decode table for one opcode page.
 Assumes the address is stable for one clock; data appears the next cycle.
*/
`default_nettype none
module odt_rom
   import odt_pkg::*;
#(
   parameter int PAGE = 0
)(
   input  wire logic       clk_sys,
   input  wire logic [7:0] addr,
   output var  odt_dec_s   rdata
);
   odt_dec_s table_q [RAM_DEPTH];

   // -----------------------------------------------------------------
   // Table build
   // -----------------------------------------------------------------
   function automatic odt_dec_s entry(input logic [7:0] op, input int page);
      odt_dec_s d;
      d = '{op: ODT_ILL, mode: AM_INH, bytes: 2'h1, base_cyc: INH_CYC, flags_hit: 1'b0, illegal: 1'b1};
      if (page != 0)
      begin
         // Only far branches and page traps are given on the follow-on pages here
         if (page == 1 && op[7:4] == 4'h2 && op != 8'h20)
            d = '{ODT_BR_L, AM_REL, 2'h0, LBR_NOT_CYC, 1'b0, 1'b0};
         else if (op == OP_SOFT_TRAP)
            d = '{ODT_TRAP, AM_INH, 2'h2, TRAP_CYC, 1'b0, 1'b0};
         return d;
      end
      case (op)
         OP_PAGE2, OP_PAGE3: d = '{ODT_PREFIX, AM_INH, 2'h1, 5'h00, 1'b0, 1'b0}; // RL9
         OP_EVENT_WAIT:  d = '{ODT_WAIT, AM_INH, 2'h1, WAIT_MIN_CYC, 1'b0, 1'b0};   // RL11
         OP_FAR_JUMP:    d = '{ODT_BR_L, AM_REL, 2'h3, LBR_NOT_CYC, 1'b0, 1'b0};
         OP_FAR_CALL:    d = '{ODT_CALL, AM_REL, 2'h3, FAR_CALL_CYC, 1'b0, 1'b0};   // RL14
         OP_DEC_FIX:     d = '{ODT_FIX, AM_INH, 2'h1, DEC_FIX_CYC, 1'b1, 1'b0};     // RL15
         OP_SWAP:        d = '{ODT_XREG, AM_IMM, 2'h2, SWAP_CYC, 1'b0, 1'b0};       // RL1
         OP_COPY:        d = '{ODT_XREG, AM_IMM, 2'h2, COPY_CYC, 1'b0, 1'b0};       // RL1
         OP_TRAP_RET:    d = '{ODT_RET, AM_INH, 2'h1, RET_SHORT_CYC, 1'b1, 1'b0};   // RL13
         OP_PRODUCT:     d = '{ODT_PROD, AM_INH, 2'h1, PRODUCT_CYC, 1'b1, 1'b0};    // RL10
         OP_SOFT_TRAP:   d = '{ODT_TRAP, AM_INH, 2'h1, TRAP_CYC, 1'b0, 1'b0};       // RL12
         default:
         begin
            if (op[7:4] == 4'h2)
               d = '{ODT_BR_S, AM_REL, 2'h2, SHORT_BR_CYC, 1'b0, 1'b0};             // RL16
            else if (op >= 8'h34 && op <= 8'h37)
               d = '{ODT_STACK, AM_INH, 2'h2, STACK_BASE_CYC, 1'b0, 1'b0};          // RL3
            else if ((op[7:4] == 4'h0 || op[7:4] == 4'h6 || op[7:4] == 4'h7)
                     && op[3:0] != 4'h1 && op[3:0] != 4'h2 && op[3:0] != 4'h5 && op[3:0] != 4'hb)
               d = '{(op[3:0] == 4'hf) ? ODT_ZSTORE : ODT_RMW,
                     (op[7:4] == 4'h0) ? AM_DIR : (op[7:4] == 4'h6) ? AM_IDX : AM_EXT,
                     (op[7:4] == 4'h7) ? 2'h3 : 2'h2,
                     (op[7:4] == 4'h7) ? RMW_EXT_CYC : RMW_IDX_CYC, 1'b1, 1'b0};    // RL17
            else if ((op[7:4] == 4'h4 || op[7:4] == 4'h5)
                     && op[3:0] != 4'h1 && op[3:0] != 4'h2 && op[3:0] != 4'h5 && op[3:0] != 4'hb
                     && op[3:0] != 4'he)
               d = '{ODT_INH, AM_INH, 2'h1, INH_CYC, 1'b1, 1'b0};
         end
      endcase
      return d; // RL6
   endfunction

   initial
   begin
      for (int i = 0; i < RAM_DEPTH; i++)
         table_q[i] = entry(i[7:0], PAGE);
   end

   always_ff @(posedge clk_sys)
   begin
      rdata <= table_q[addr];
   end
endmodule
`default_nettype wire

// ===== logic/odt_core.sv
/*
 Opcode decode and cycle timing: classifies fetched bytes, follows prefix
 pages, counts bus cycles and runs the read-before-write clear sequence.
 Assumes the processor bus returns read data in the cycle after a strobe.
*/
// Contract
// (RL1) Swap and copy accept 8-bit or 16-bit pairs
// (RL2) Defines the 8-bit and 16-bit register sets
// (RL3) Stack save/restore: five plus one per byte
// (RL4) Far conditional branch: five, or six taken
// (RL5) First trap masks both; other traps don't
// (RL6) Unassigned opcodes are undefined and illegal
// (RL7) Zero store reads target, then writes zero
// (RL8) Extended zero store runs fixed seven cycles
// (RL9) Bytes 10 and 11 select further pages
// (RL10) Opcode 3D: product, one byte, eleven cycles
// (RL11) Opcode 13: event wait, at least four
// (RL12) Opcode 3F: soft trap, nineteen cycles
// (RL13) Opcode 3B: trap return, six or fifteen
// (RL14) Opcode 17: far call, three bytes, nine
// (RL15) Opcode 19: decimal fix, two cycles
// (RL16) Opcode 20: short jump, always three cycles
// (RL17) Read-modify-write extended seven, indexed six plus
// (RL18) Indexed and stack extras add to base
// (RL19) Flags change only when flags named
// (RL20) Half-carry undefined where marked
// (RL21) Marked case: carry follows result bit 7
// (RL22) Unassigned opcode raises illegal indication
`default_nettype none
module odt_core
   import odt_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        op_valid,
   input  wire logic [7:0]  op_byte,
   input  wire logic [7:0]  post_byte,
   input  wire logic [3:0]  idx_extra,
   input  wire logic        cond_true,
   input  wire logic        full_restore,
   input  wire logic [15:0] target_addr,
   input  wire logic [7:0]  bus_rdata,
   input  wire logic [7:0]  result_in,
   output var  odt_dec_s    dec,
   output logic             dec_valid,
   output logic [4:0]       total_cyc,
   output logic             illegal_op,
   output logic             prefix_seen,
   output logic [1:0]       page,
   output logic             set_irq_mask,
   output logic             set_fast_mask,
   output logic             flags_we,
   output logic             carry_out,
   output logic             reg_pair_ok,
   output var  odt_bus_s    bus,
   output logic             busy,
   output logic [7:0]       read_back
);
   import odt_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0, ST_LOOK = 3'h1, ST_DUMMY1 = 3'h2, ST_READ = 3'h3, ST_DUMMY2 = 3'h4, ST_WRITE = 3'h5
   } odt_state_e;

   // -----------------------------------------------------------------
   // Page decode tables
   // -----------------------------------------------------------------
   odt_dec_s tab_q [3];
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_page
         odt_rom #(.PAGE(g)) u_rom (
            .clk_sys (clk_sys),
            .addr    (op_byte),
            .rdata   (tab_q[g])
         );
      end
   endgenerate

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   // Counts bits set in a save/restore post byte; 16-bit entries count twice
   function automatic logic [4:0] stack_bytes(input logic [7:0] pb);
      logic [4:0] n;
      n = 5'h00;
      for (int i = 0; i < 8; i++)
         if (pb[i])
            n = n + ((i >= 4) ? 5'h02 : 5'h01);
      return n;
   endfunction

   // Register selector width class: 0 = 16-bit, 1 = 8-bit, 2 = undefined
   function automatic logic [1:0] reg_class(input logic [3:0] sel);
      if (sel <= 4'h5)
         return 2'h0; // RL2
      else if (sel >= 4'h8 && sel <= 4'hb)
         return 2'h1; // RL2
      else
         return 2'h2;
   endfunction

   // -----------------------------------------------------------------
   // Decode stage
   // -----------------------------------------------------------------
   logic        look;
   logic [7:0]  op_q;
   logic [1:0]  page_q;
   logic [7:0]  post_q;
   logic [3:0]  idx_q;
   logic        cond_q;
   logic        full_q;
   logic [1:0]  next_page;
   logic        next_look;
   odt_dec_s    cur;
   logic [4:0]  next_total;
   logic        next_illegal;
   logic        next_trap_masks;

   always_comb
   begin
      cur = tab_q[page_q];
      next_look = op_valid;
      next_page = page_q;
      next_total = cur.base_cyc;
      next_illegal = 1'b0;
      next_trap_masks = 1'b0;
      if (look)
      begin
         if (cur.op == ODT_PREFIX && page_q == 2'h0)
            // Page picked from the byte being decoded; the live input may already hold the next one
            next_page = (op_q == OP_PAGE2) ? 2'h1 : 2'h2; // RL9
         else
            next_page = 2'h0;
         case (cur.op)
            ODT_STACK: next_total = STACK_BASE_CYC + stack_bytes(post_q) * STACK_BYTE_CYC; // RL3 RL18
            ODT_BR_L:  next_total = cond_q ? LBR_TAKEN_CYC : LBR_NOT_CYC;              // RL4
            ODT_RET:   next_total = full_q ? RET_LONG_CYC : RET_SHORT_CYC;             // RL13
            ODT_TRAP:  next_trap_masks = (page_q == 2'h0);                              // RL5
            ODT_ILL:   next_illegal = 1'b1;                                             // RL6 RL22
            ODT_PREFIX: next_total = 5'h00;
            default:   next_total = cur.base_cyc;
         endcase
         if (cur.mode == AM_IDX)
            next_total = cur.base_cyc + {1'b0, idx_q};                                   // RL17 RL18
         if (cur.op == ODT_BR_L && page_q == 2'h0)
            next_total = LBR_NOT_CYC;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         look <= 1'b0;
         op_q <= 8'h00;
         page_q <= 2'h0;
         post_q <= 8'h00;
         idx_q <= 4'h0;
         cond_q <= 1'b0;
         full_q <= 1'b0;
         total_cyc <= 5'h00;
         illegal_op <= 1'b0;
         set_irq_mask <= 1'b0;
         set_fast_mask <= 1'b0;
         dec <= '0;
         dec_valid <= 1'b0;
         prefix_seen <= 1'b0;
      end
      else
      begin
         look <= next_look;
         op_q <= op_byte;
         page_q <= next_page;
         post_q <= post_byte;
         idx_q <= idx_extra;
         cond_q <= cond_true;
         full_q <= full_restore;
         total_cyc <= look ? next_total : total_cyc;
         illegal_op <= next_illegal;
         set_irq_mask <= next_trap_masks;   // RL5
         set_fast_mask <= next_trap_masks;  // RL5
         dec <= look ? cur : dec;
         dec_valid <= look && cur.op != ODT_PREFIX;
         prefix_seen <= look && cur.op == ODT_PREFIX && page_q == 2'h0;
      end
   end

   assign page = page_q;

   // Swap/copy need both operands of one width class
   assign reg_pair_ok = dec.op == ODT_XREG && reg_class(post_q[7:4]) == reg_class(post_q[3:0])
                        && reg_class(post_q[3:0]) != 2'h2; // RL1

   // Flags written only by flag-affecting ops or a swap/copy naming them
   assign flags_we = dec_valid && (dec.flags_hit
                     || (dec.op == ODT_XREG && post_q[3:0] == REGSEL_CC)); // RL19
   // Half-carry left as computed; marked case carry tracks bit 7
   assign carry_out = result_in[7]; // RL20 RL21

   // -----------------------------------------------------------------
   // Zero store bus sequence
   // -----------------------------------------------------------------
   odt_state_e  state;
   odt_state_e  next_state;
   odt_bus_s    next_bus;
   logic [7:0]  next_read_back;

   always_comb
   begin
      next_state = state;
      next_bus = '{addr: DUMMY_ADDR, wdata: ZERO_DATA, rd: 1'b0, wr: 1'b0};
      next_read_back = read_back;
      case (state)
         ST_IDLE:
         begin
            if (dec_valid && dec.op == ODT_ZSTORE)
               next_state = (dec.mode == AM_EXT) ? ST_DUMMY1 : ST_READ;
         end
         ST_DUMMY1:
         begin
            next_bus.rd = 1'b1; // RL8
            next_state = ST_READ;
         end
         ST_READ:
         begin
            next_bus = '{addr: target_addr, wdata: ZERO_DATA, rd: 1'b1, wr: 1'b0}; // RL7
            next_state = ST_DUMMY2;
         end
         ST_DUMMY2:
         begin
            next_bus.rd = 1'b1; // RL8
            next_state = ST_WRITE;
         end
         ST_WRITE:
         begin
            next_bus = '{addr: target_addr, wdata: ZERO_DATA, rd: 1'b0, wr: 1'b1}; // RL7
            // Target data lands one cycle after its strobe, which is this state
            next_read_back = bus_rdata; // RL7
            next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         state <= ST_IDLE;
         bus <= '{addr: DUMMY_ADDR, wdata: ZERO_DATA, rd: 1'b0, wr: 1'b0};
         read_back <= 8'h00;
      end
      else
      begin
         state <= next_state;
         bus <= next_bus;
         read_back <= next_read_back;
      end
   end

   assign busy = state != ST_IDLE;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   a_write_after_read: assert property (@(posedge clk_sys) disable iff (srst) // RL7
      bus.wr |-> $past(bus.rd, 2) && bus.wdata == ZERO_DATA && bus.addr == $past(bus.addr, 2))
      else $error("zero store write without prior read");
   a_dummy_addr: assert property (@(posedge clk_sys) disable iff (srst) // RL8
      bus.wr |-> $past(bus.addr, 1) == DUMMY_ADDR)
      else $error("zero store missing dummy cycle");
   a_product_cyc: assert property (@(posedge clk_sys) disable iff (srst) // RL10
      dec_valid && dec.op == ODT_PROD |-> total_cyc == 5'h0b)
      else $error("product cycle count wrong");
   a_trap_cyc: assert property (@(posedge clk_sys) disable iff (srst) // RL12
      dec_valid && dec.op == ODT_TRAP |-> total_cyc == 5'h13)
      else $error("soft trap cycle count wrong");
   a_trap_masks: assert property (@(posedge clk_sys) disable iff (srst) // RL5
      set_irq_mask |-> set_fast_mask && dec.op == ODT_TRAP && $past(page_q) == 2'h0)
      else $error("trap mask set wrongly");
   a_far_branch: assert property (@(posedge clk_sys) disable iff (srst) // RL4
      dec_valid && dec.op == ODT_BR_L && dec.bytes == 2'h0 |-> total_cyc == ($past(cond_q) ? 5'h06 : 5'h05))
      else $error("far branch cycles wrong");
   a_short_branch: assert property (@(posedge clk_sys) disable iff (srst) // RL16
      dec_valid && dec.op == ODT_BR_S |-> total_cyc == 5'h03)
      else $error("short branch cycles wrong");
   a_illegal_flag: assert property (@(posedge clk_sys) disable iff (srst) // RL22
      dec_valid && dec.op == ODT_ILL |-> illegal_op)
      else $error("illegal opcode not flagged");
   a_prefix_quiet: assert property (@(posedge clk_sys) disable iff (srst) // RL9
      prefix_seen |-> !dec_valid ##1 page_q != 2'h0 || !look)
      else $error("prefix executed on its own");
endmodule
`default_nettype wire

// ===== dv/odt_mem_model.sv
/*
 Program and data memory on the processor bus, for the decode bench.
 Assumes one strobe per cycle; read data is returned in the following cycle.
*/
`default_nettype none
module odt_mem_model
   import odt_pkg::*;
#(
   parameter logic [7:0] STAT_ADDR = 8'h40
)(
   input  wire odt_bus_s   bus,
   input  wire logic       clk_sys,
   output logic [7:0]      bus_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [RAM_DEPTH];

   initial
   begin
      bus_rdata = 8'h00;
      foreach (mem[i]) mem[i] = 8'h00;
   end

   always @(posedge clk_sys)
   begin
      if (bus.rd)
      begin
         bus_rdata <= mem[bus.addr[7:0]];
         // Status byte clears on read, so a needless read is visible
         if (bus.addr[7:0] == STAT_ADDR)
            mem[STAT_ADDR] <= 8'h00;
      end
      else
         // Idle bus never repeats stale data
         bus_rdata <= ~bus_rdata;
      if (bus.wr)
         mem[bus.addr[7:0]] <= bus.wdata;
   end
endmodule
`default_nettype wire

// ===== dv/opcode_decode_timing_tb.sv
/*
 Self-checking bench for the opcode decode and timing core.
 Assumes the memory model answers bus reads one cycle after the strobe.
*/
`default_nettype none
module opcode_decode_timing_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import odt_pkg::*;
   typedef struct packed {
      logic [7:0] pre; logic [7:0] opc; logic [7:0] post; logic [3:0] idx; logic cond; logic full;
      odt_op_e op; logic [1:0] nb; logic [4:0] cyc; logic ckc; logic ill; logic msk;
   } odt_row_s;
   logic        clk_sys, srst, op_valid, cond_true, full_restore;
   logic [7:0]  op_byte, post_byte, bus_rdata, result_in, read_back;
   logic [3:0]  idx_extra;
   logic [15:0] target_addr;
   odt_dec_s    dec;
   odt_bus_s    bus;
   logic        dec_valid, illegal_op, prefix_seen, set_irq_mask, set_fast_mask, flags_we, carry_out;
   logic        reg_pair_ok, busy;
   logic [4:0]  total_cyc;
   logic [1:0]  page;
   int          n_mismatch = 0;
   int          n_checks = 0;
   odt_row_s    rows [19];

   odt_core i_dut (.clk_sys(clk_sys), .srst(srst), .op_valid(op_valid), .op_byte(op_byte),
      .post_byte(post_byte), .idx_extra(idx_extra), .cond_true(cond_true), .full_restore(full_restore),
      .target_addr(target_addr), .bus_rdata(bus_rdata), .result_in(result_in), .dec(dec),
      .dec_valid(dec_valid), .total_cyc(total_cyc), .illegal_op(illegal_op), .prefix_seen(prefix_seen),
      .page(page), .set_irq_mask(set_irq_mask), .set_fast_mask(set_fast_mask), .flags_we(flags_we),
      .carry_out(carry_out), .reg_pair_ok(reg_pair_ok), .bus(bus), .busy(busy), .read_back(read_back));
   odt_mem_model i_mem (.bus(bus), .clk_sys(clk_sys), .bus_rdata(bus_rdata));

   // ----------------------------------------------------------------
   // Clock, watchdog and report
   // ----------------------------------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   initial
   begin
      // Whole run is well under two thousand cycles
      #100000;
      n_mismatch++;
      wrap_up();
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // ----------------------------------------------------------------
   // Drivers
   // ----------------------------------------------------------------
   task automatic send(input logic [7:0] b);
      @(posedge clk_sys);
      #1 op_valid = 1'b1;
      op_byte = b;
      @(posedge clk_sys);
      #1 op_valid = 1'b0;
   endtask

   // Bounded wait for any decode result
   task automatic wait_out();
      repeat (4)
      begin
         @(posedge clk_sys);
         #1;
         if (dec_valid === 1'b1 || illegal_op === 1'b1 || prefix_seen === 1'b1)
            return;
      end
   endtask

   task automatic run_row(input odt_row_s r);
      post_byte = r.post;
      idx_extra = r.idx;
      cond_true = r.cond;
      full_restore = r.full;
      if (r.pre != 8'h00)
      begin
         send(r.pre);
         wait_out();
         chk_bit("prefix_seen", 1'b1, prefix_seen);
         chk_bit("prefix_dec_valid", 1'b0, dec_valid);
         chk_val("page", (r.pre == OP_PAGE2) ? 16'h0001 : 16'h0002, 16'(page));
      end
      send(r.opc);
      wait_out();
      // Illegal codes still complete a decode; the illegal flag marks them
      chk_bit("dec_valid", 1'b1, dec_valid);
      chk_bit("illegal_op", r.ill, illegal_op);
      chk_val("op", 16'(r.op), 16'(dec.op));
      chk_bit("irq_mask", r.msk, set_irq_mask);
      chk_bit("fast_mask", r.msk, set_fast_mask);
      if (r.ckc)
      begin
         chk_val("total_cyc", 16'(r.cyc), 16'(total_cyc));
         chk_val("bytes", 16'(r.nb), 16'(dec.bytes));
      end
   endtask

   task automatic zs_test(input logic [7:0] opc);
      int rdc;
      int wrc;
      logic [7:0] wd;
      rdc = 0;
      wrc = 0;
      wd = 8'hff;
      i_mem.mem[8'h40] = 8'h5a;
      target_addr = 16'h0040;
      send(opc);
      for (int k = 1; k <= 9; k++)
      begin
         @(posedge clk_sys);
         #1;
         if (bus.rd === 1'b1 && bus.addr === 16'h0040 && rdc == 0)
            rdc = k;
         if (bus.wr === 1'b1)
         begin
            wrc = k;
            wd = bus.wdata;
         end
         chk_bit("zs_busy", k >= 2 && k <= ((opc == OP_ZS_EXT) ? 5 : 4), busy);
         if (opc == OP_ZS_EXT && k >= 3 && k <= 6)
         begin
            chk_val("zs_addr", (k == 4 || k == 6) ? 16'h0040 : DUMMY_ADDR, bus.addr);
            chk_bit("zs_wr", k == 6, bus.wr);
         end
      end
      chk_bit("read_first", rdc > 0 && wrc > rdc, 1'b1);
      chk_val("zs_wdata", 16'(ZERO_DATA), 16'(wd));
      chk_val("read_back", 16'h005a, 16'(read_back));
      chk_val("zs_mem", 16'h0000, 16'(i_mem.mem[8'h40]));
      $display("test zero_store %h done", opc);
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      rows = '{
         '{8'h00, 8'h3d, 8'h00, 4'h0, 1'b0, 1'b0, ODT_PROD, 2'h1, 5'h0b, 1'b1, 1'b0, 1'b0},
         '{8'h00, 8'h13, 8'h00, 4'h0, 1'b0, 1'b0, ODT_WAIT, 2'h1, 5'h04, 1'b1, 1'b0, 1'b0},
         '{8'h00, 8'h3f, 8'h00, 4'h0, 1'b0, 1'b0, ODT_TRAP, 2'h1, 5'h13, 1'b1, 1'b0, 1'b1},
         '{8'h00, 8'h3b, 8'h00, 4'h0, 1'b0, 1'b0, ODT_RET, 2'h1, 5'h06, 1'b1, 1'b0, 1'b0},
         '{8'h00, 8'h3b, 8'h00, 4'h0, 1'b0, 1'b1, ODT_RET, 2'h1, 5'h0f, 1'b1, 1'b0, 1'b0},
         '{8'h00, 8'h17, 8'h00, 4'h0, 1'b0, 1'b0, ODT_CALL, 2'h3, 5'h09, 1'b1, 1'b0, 1'b0},
         '{8'h00, 8'h19, 8'h00, 4'h0, 1'b0, 1'b0, ODT_FIX, 2'h1, 5'h02, 1'b1, 1'b0, 1'b0},
         '{8'h00, 8'h20, 8'h00, 4'h0, 1'b0, 1'b0, ODT_BR_S, 2'h2, 5'h03, 1'b1, 1'b0, 1'b0},
         '{8'h00, 8'h20, 8'h00, 4'h0, 1'b1, 1'b0, ODT_BR_S, 2'h2, 5'h03, 1'b1, 1'b0, 1'b0},
         '{8'h00, 8'h70, 8'h00, 4'h0, 1'b0, 1'b0, ODT_RMW, 2'h3, 5'h07, 1'b1, 1'b0, 1'b0},
         '{8'h00, 8'h60, 8'h00, 4'h3, 1'b0, 1'b0, ODT_RMW, 2'h2, 5'h09, 1'b1, 1'b0, 1'b0},
         '{8'h00, 8'h34, 8'hff, 4'h0, 1'b0, 1'b0, ODT_STACK, 2'h2, 5'h11, 1'b1, 1'b0, 1'b0},
         '{8'h00, 8'h37, 8'h0f, 4'h0, 1'b0, 1'b0, ODT_STACK, 2'h2, 5'h09, 1'b1, 1'b0, 1'b0},
         '{8'h00, 8'h01, 8'h00, 4'h0, 1'b0, 1'b0, ODT_ILL, 2'h0, 5'h00, 1'b0, 1'b1, 1'b0},
         '{8'h00, 8'h4e, 8'h00, 4'h0, 1'b0, 1'b0, ODT_ILL, 2'h0, 5'h00, 1'b0, 1'b1, 1'b0},
         '{8'h10, 8'h26, 8'h00, 4'h0, 1'b0, 1'b0, ODT_BR_L, 2'h0, 5'h05, 1'b1, 1'b0, 1'b0},
         '{8'h10, 8'h26, 8'h00, 4'h0, 1'b1, 1'b0, ODT_BR_L, 2'h0, 5'h06, 1'b1, 1'b0, 1'b0},
         '{8'h10, 8'h3f, 8'h00, 4'h0, 1'b0, 1'b0, ODT_TRAP, 2'h0, 5'h00, 1'b0, 1'b0, 1'b0},
         '{8'h11, 8'h3f, 8'h00, 4'h0, 1'b0, 1'b0, ODT_TRAP, 2'h0, 5'h00, 1'b0, 1'b0, 1'b0}};
      {srst, op_valid, cond_true, full_restore} = 4'h8;
      {op_byte, post_byte, result_in, idx_extra} = 28'h0;
      target_addr = 16'h0000;
      repeat (6) @(posedge clk_sys);
      #1;
      chk_bit("rst_dec_valid", 1'b0, dec_valid);
      chk_val("rst_addr", DUMMY_ADDR, bus.addr);
      srst = 1'b0;
      $display("test reset done");
      foreach (rows[i]) run_row(rows[i]);
      $display("test table done");
      // Back to back: two decodes on consecutive cycles
      @(posedge clk_sys);
      #1 op_valid = 1'b1;
      op_byte = OP_DEC_FIX;
      @(posedge clk_sys);
      #1 op_byte = OP_PRODUCT;
      @(posedge clk_sys);
      #1 op_valid = 1'b0;
      chk_val("b2b_first", 16'(DEC_FIX_CYC), 16'(total_cyc));
      @(posedge clk_sys);
      #1 chk_val("b2b_second", 16'(PRODUCT_CYC), 16'(total_cyc));
      chk_bit("b2b_valid", 1'b1, dec_valid);
      $display("test back_to_back done");
      zs_test(OP_ZS_EXT);
      zs_test(8'h0f);
      zs_test(8'h6f);
      // Selector pairs: 8-bit 89 and 8a, 16-bit 12, mixed 08 refused
      for (int i = 0; i < 4; i++)
      begin
         post_byte = 32'h898a0812 >> (24 - 8 * i);
         send(i[0] ? OP_COPY : OP_SWAP);
         wait_out();
         chk_bit("pair_ok", i != 2, reg_pair_ok);
         chk_bit("flags_we", i == 1, flags_we);
      end
      foreach (rows[i])
      begin
         result_in = 8'h37 ^ (8'h80 & 8'(i << 7));
         #1 chk_bit("carry_out", result_in[7], carry_out);
      end
      $display("test pairs_flags done");
      // Reset in the middle of a trap decode drops its pulses
      send(OP_SOFT_TRAP);
      srst = 1'b1;
      @(posedge clk_sys);
      #1 chk_bit("mid_rst_valid", 1'b0, dec_valid);
      chk_bit("mid_rst_mask", 1'b0, set_irq_mask);
      chk_val("mid_rst_addr", DUMMY_ADDR, bus.addr);
      srst = 1'b0;
      send(OP_JUMP_ALWAYS);
      wait_out();
      chk_val("after_rst_cyc", 16'(SHORT_BR_CYC), 16'(total_cyc));
      $display("test mid_reset done");
      wrap_up();
   end
endmodule
`default_nettype wire
